// file: fdmd_pkg.sv
package fdmd_pkg;
  localparam int unsigned fdmd_addr_w = 12;
  localparam logic [11:0] fdmd_off_ctrl = 12'h000;
  localparam logic [11:0] fdmd_off_status = 12'h004;
  localparam int fdmd_ctrl_mode_lsb = 0;
  localparam int fdmd_ctrl_force_bit = 2;
  localparam int fdmd_ctrl_ov_lsb = 4;
  localparam int fdmd_st_conv_lsb = 0;
  localparam int fdmd_st_led_lsb = 4;
  localparam int fdmd_st_stage_bit = 8;
  localparam int fdmd_st_batt_bit = 9;
  localparam int fdmd_st_sinks_bit = 10;
  localparam int fdmd_st_ov_lsb = 12;
  localparam logic [1:0] fdmd_mode_rst = 2'h0;
  localparam logic [3:0] fdmd_ov_rst = 4'h0;
  localparam logic [1:0] fdmd_mode_off = 2'h0;
  localparam logic [1:0] fdmd_mode_dcl = 2'h1;
  localparam logic [1:0] fdmd_mode_flash = 2'h2;
  localparam logic [1:0] fdmd_mode_volt = 2'h3;

  typedef enum logic [1:0] {
    fdmd_conv_shutdown = 2'b00,
    fdmd_conv_current = 2'b01,
    fdmd_conv_voltage = 2'b10
  } fdmd_conv_e;

  typedef enum logic [1:0] {
    fdmd_led_off = 2'b00,
    fdmd_led_dc = 2'b01,
    fdmd_led_flash = 2'b10
  } fdmd_led_e;

  typedef struct packed {
    logic [1:0] mode;
    logic voltage_mode_force;
    logic [3:0] output_voltage_code;
    logic high_current_select;
    logic strobe;
  } fdmd_req_s;

  typedef struct packed {
    fdmd_conv_e conv;
    fdmd_led_e led;
    logic stage_on;
    logic battery_path;
    logic low_side_sinks;
    logic [3:0] output_voltage_code;
  } fdmd_dec_s;
endpackage : fdmd_pkg

// file: fdmd_decode.sv
`timescale 1ns/1ps
module fdmd_decode
  import fdmd_pkg::*;
(
  input fdmd_pkg::fdmd_req_s req,
  output fdmd_pkg::fdmd_dec_s dec
);
  import fdmd_pkg::*;

  always_comb
  begin
    dec = '0;
    dec.output_voltage_code = req.output_voltage_code;
    case ({req.mode, req.voltage_mode_force})
      {fdmd_mode_off, 1'b0}:
      begin
        dec.conv = fdmd_conv_shutdown;
        dec.led = fdmd_led_off;
      end
      {fdmd_mode_dcl, 1'b0}:
      begin
        dec.conv = fdmd_conv_current;
        dec.led = fdmd_led_dc;
        dec.battery_path = 1'b1;
        dec.stage_on = 1'b1;
      end
      {fdmd_mode_flash, 1'b0}:
      begin
        dec.conv = fdmd_conv_current;
        dec.led = fdmd_led_flash;
        dec.battery_path = 1'b1;
        dec.stage_on = !(req.high_current_select && req.strobe);
      end
      {fdmd_mode_dcl, 1'b1}:
      begin
        dec.conv = fdmd_conv_voltage;
        dec.led = fdmd_led_dc;
        dec.stage_on = 1'b1;
        dec.battery_path = 1'b1;
        dec.low_side_sinks = 1'b1;
      end
      {fdmd_mode_flash, 1'b1}:
      begin
        dec.conv = fdmd_conv_voltage;
        dec.led = fdmd_led_flash;
        dec.low_side_sinks = 1'b1;
        dec.battery_path = !req.high_current_select;
        dec.stage_on = req.high_current_select;
      end
      default:
      begin
        dec.conv = fdmd_conv_voltage;
        dec.led = fdmd_led_off;
        dec.stage_on = 1'b1;
      end
    endcase
  end
endmodule : fdmd_decode

// file: fdmd_top.sv
// Summary of operation
// - Mode 00 without forcing: converter shut down, load disconnected from battery.
// - Mode 01 without forcing: DC light, current regulation, battery feeds output.
// - Mode 10 without forcing: current regulation, LEDs armed for flash, battery feeds output.
// - Flash-ready current mode with high current: stage off during strobe.
// - Mode 11, or 00/11 forced: LEDs off, regulate voltage from code.
// - Mode 01 forced: voltage regulation plus DC light through low-side sinks.
// - Mode 10 forced: voltage regulation, LEDs armed for flash via sinks.
// - Forced flash-ready: battery direct if high current low, else stage runs.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fdmd_top
  import fdmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fdmd_pkg::fdmd_addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_current_select,
  input wire logic strobe,
  output fdmd_pkg::fdmd_conv_e conv_state,
  output fdmd_pkg::fdmd_led_e led_state,
  output logic stage_on,
  output logic battery_path,
  output logic low_side_sinks,
  output logic [3:0] output_voltage_code
);
  import fdmd_pkg::*;

  logic [1:0] mode;
  logic voltage_mode_force;
  logic [3:0] ov_code;
  logic hc_meta;
  logic hc_sync;
  logic st_meta;
  logic st_sync;
  fdmd_req_s req;
  fdmd_dec_s dec;
  logic access;
  logic done;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  function automatic logic is_ctrl(input logic [fdmd_addr_w-1:0] a);
    is_ctrl = (a == fdmd_off_ctrl);
  endfunction : is_ctrl

  function automatic logic is_status(input logic [fdmd_addr_w-1:0] a);
    is_status = (a == fdmd_off_status);
  endfunction : is_status

  function automatic logic mapped(input logic [fdmd_addr_w-1:0] a);
    mapped = is_ctrl(a) || is_status(a);
  endfunction : mapped

  assign access = psel && penable && !pready;

  // A write lands only on the completing edge, so a stalled transfer never changes the mode early.
  assign done = psel && penable && pready;

  // Pins cross into pclk through two flops before anything decodes them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hc_meta <= 1'b0;
      hc_sync <= 1'b0;
    end
    else
    begin
      hc_meta <= high_current_select;
      hc_sync <= hc_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_meta <= 1'b0;
      st_sync <= 1'b0;
    end
    else
    begin
      st_meta <= strobe;
      st_sync <= st_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= fdmd_mode_rst;
      voltage_mode_force <= 1'b0;
      ov_code <= fdmd_ov_rst;
    end
    else if (done && pwrite && is_ctrl(paddr) && pstrb[0])
    begin
      mode <= pwdata[fdmd_ctrl_mode_lsb +: 2];
      voltage_mode_force <= pwdata[fdmd_ctrl_force_bit];
      ov_code <= pwdata[fdmd_ctrl_ov_lsb +: 4];
    end
  end

  always_comb
  begin
    req = '0;
    req.mode = mode;
    req.voltage_mode_force = voltage_mode_force;
    req.output_voltage_code = ov_code;
    req.high_current_select = hc_sync;
    req.strobe = st_sync;
  end

  fdmd_decode u_decode (
    .req(req),
    .dec(dec)
  );

  // Outputs are re-registered every cycle, so any input change takes effect without a command.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_state <= fdmd_conv_shutdown;
      led_state <= fdmd_led_off;
      stage_on <= 1'b0;
      battery_path <= 1'b0;
      low_side_sinks <= 1'b0;
      output_voltage_code <= fdmd_ov_rst;
    end
    else
    begin
      conv_state <= dec.conv;
      led_state <= dec.led;
      stage_on <= dec.stage_on;
      battery_path <= dec.battery_path;
      low_side_sinks <= dec.low_side_sinks;
      output_voltage_code <= dec.output_voltage_code;
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[fdmd_st_conv_lsb +: 2] = conv_state;
    status_word[fdmd_st_led_lsb +: 2] = led_state;
    status_word[fdmd_st_stage_bit] = stage_on;
    status_word[fdmd_st_batt_bit] = battery_path;
    status_word[fdmd_st_sinks_bit] = low_side_sinks;
    status_word[fdmd_st_ov_lsb +: 4] = output_voltage_code;
  end

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[fdmd_ctrl_mode_lsb +: 2] = mode;
    ctrl_word[fdmd_ctrl_force_bit] = voltage_mode_force;
    ctrl_word[fdmd_ctrl_ov_lsb +: 4] = ov_code;
  end

  // One wait state keeps the read data registered; the answer comes on the second access edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= access;
    end
  end

  // Unmapped addresses answer with an error and never write anything.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= access && !mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (access && !pwrite && is_ctrl(paddr))
    begin
      prdata <= ctrl_word;
    end
    else if (access && !pwrite && is_status(paddr))
    begin
      prdata <= status_word;
    end
    else
    begin
      prdata <= '0;
    end
  end

  // Field positions live in the package; a layout that pushes either ov field or the sinks bit off the word is refused.
  if (fdmd_ctrl_ov_lsb + 4 > 32 || fdmd_st_ov_lsb + 4 > 32 || fdmd_st_sinks_bit > 31)
  begin : g_field_check
    $error("A register field lies outside the 32-bit data word.");
  end

  // Both registers must be distinct aligned words.
  if (fdmd_off_ctrl[1:0] != 2'h0 || fdmd_off_status[1:0] != 2'h0 || fdmd_off_ctrl == fdmd_off_status)
  begin : g_map_check
    $error("Register offsets must be distinct word addresses.");
  end

  // The address decode compares against twelve-bit offsets.
  if (fdmd_addr_w != 12)
  begin : g_addr_check
    $error("Address width must match the twelve-bit register offsets.");
  end
endmodule : fdmd_top

// file: fdmd_props.sv
`timescale 1ns/1ps
module fdmd_props
  import fdmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [fdmd_pkg::fdmd_addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic high_current_select,
  input wire logic strobe,
  input fdmd_pkg::fdmd_conv_e conv_state,
  input fdmd_pkg::fdmd_led_e led_state,
  input wire logic stage_on,
  input wire logic battery_path,
  input wire logic low_side_sinks,
  input wire logic [3:0] output_voltage_code
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire cur = conv_state == fdmd_conv_current;
  wire vlt = conv_state == fdmd_conv_voltage;
  // Four samples cover the two sync flops plus the output register.
  sequence s_hi;
    high_current_select[*4];
  endsequence
  sequence s_lo;
    (!high_current_select)[*4];
  endsequence
  sequence s_hc_strobe;
    (high_current_select && strobe)[*4];
  endsequence
  sequence s_ctrl_write;
    psel && penable && pready && pwrite && paddr == fdmd_off_ctrl && pstrb[0];
  endsequence
  property p_off;
    conv_state == fdmd_conv_shutdown |-> !{led_state, stage_on, battery_path, low_side_sinks};
  endproperty
  a_off: assert property (p_off) else $error("off");
  property p_cdc;
    cur && led_state == fdmd_led_dc |-> stage_on && battery_path && !low_side_sinks;
  endproperty
  a_cdc: assert property (p_cdc) else $error("cdc");
  property p_cfl;
    cur && led_state == fdmd_led_flash |-> battery_path && !low_side_sinks;
  endproperty
  a_cfl: assert property (p_cfl) else $error("cfl");
  property p_hc;
    s_hc_strobe ##0 (cur && led_state == fdmd_led_flash) |-> !stage_on;
  endproperty
  a_hc: assert property (p_hc) else $error("hc");
  property p_voff;
    vlt && led_state == fdmd_led_off |-> stage_on && !low_side_sinks;
  endproperty
  a_voff: assert property (p_voff) else $error("voff");
  property p_vdc;
    vlt && led_state == fdmd_led_dc |-> stage_on && battery_path && low_side_sinks;
  endproperty
  a_vdc: assert property (p_vdc) else $error("vdc");
  property p_vfl;
    s_hi ##0 (vlt && led_state == fdmd_led_flash) |-> stage_on && !battery_path && low_side_sinks;
  endproperty
  a_vfl: assert property (p_vfl) else $error("vfl");
  property p_vlo;
    s_lo ##0 (vlt && led_state == fdmd_led_flash) |-> !stage_on && battery_path && low_side_sinks;
  endproperty
  a_vlo: assert property (p_vlo) else $error("vlo");
  property p_ov;
    s_ctrl_write |-> ##2 output_voltage_code == $past(pwdata[fdmd_ctrl_ov_lsb +: 4], 2);
  endproperty
  a_ov: assert property (p_ov) else $error("ov");
endmodule : fdmd_props
bind fdmd_top fdmd_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pstrb(pstrb),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .high_current_select(high_current_select),
  .strobe(strobe),
  .conv_state(conv_state),
  .led_state(led_state),
  .stage_on(stage_on),
  .battery_path(battery_path),
  .low_side_sinks(low_side_sinks),
  .output_voltage_code(output_voltage_code)
);

// file: fdmd_test.sv
`timescale 1ns/1ps
module fdmd_test;
  import fdmd_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr, er;
  logic high_current_select = '0, strobe = '0, stage_on, battery_path, low_side_sinks;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, output_voltage_code;
  fdmd_conv_e conv_state;
  fdmd_led_e led_state;
  wire [6:0] pins = {low_side_sinks, battery_path, stage_on, led_state, conv_state};
  int error_cnt = 0, checked = 0;
  fdmd_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .high_current_select(high_current_select),
    .strobe(strobe),
    .conv_state(conv_state),
    .led_state(led_state),
    .stage_on(stage_on),
    .battery_path(battery_path),
    .low_side_sinks(low_side_sinks),
    .output_voltage_code(output_voltage_code)
  );
  always #12.5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // An idle edge first, so a release and the next setup never share a time step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  function automatic logic [6:0] exp_st(input logic [4:0] i);
    case (i[2:0])
      3'h0: return 7'h00;
      3'h1: return {3'h3, fdmd_led_dc, fdmd_conv_current};
      3'h2: return {2'h1, !(i[3] && i[4]), fdmd_led_flash, fdmd_conv_current};
      3'h5: return {3'h7, fdmd_led_dc, fdmd_conv_voltage};
      3'h6: return {1'h1, !i[3], i[3], fdmd_led_flash, fdmd_conv_voltage};
      default: return {3'h1, fdmd_led_off, fdmd_conv_voltage};
    endcase
  endfunction : exp_st
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, fdmd_off_status, '0);
    chk("status", rd, '0);
    $display("reset test done");
    for (int i = 0; i < 32; i++)
    begin
      xfer(1'h1, fdmd_off_ctrl, {24'h0, i[3:0], 1'h0, i[2:0]});
      high_current_select <= i[3];
      strobe <= i[4];
      repeat (4) @(posedge pclk);
      xfer(1'h0, fdmd_off_status, '0);
      chk("decode", {rd[10:8], rd[5:4], rd[1:0]}, exp_st(i[4:0]));
      chk("decode pins", pins, exp_st(i[4:0]));
      chk("ov code", {rd[15:12], output_voltage_code}, {2{i[3:0]}});
      xfer(1'h0, fdmd_off_ctrl, '0);
      chk("ctrl readback", rd, {24'h0, i[3:0], 1'h0, i[2:0]});
    end
    $display("mode test done");
    high_current_select <= 1'h0;
    xfer(1'h1, fdmd_off_ctrl, 32'h0000_0006);
    repeat (4) @(posedge pclk);
    chk("pin low", pins, exp_st(5'h16));
    high_current_select <= 1'h1;
    repeat (4) @(posedge pclk);
    chk("pin high", pins, exp_st(5'h1e));
    $display("pin test done");
    xfer(1'h0, 12'h008, '0);
    chk("unmapped err", er, 1'h1);
    chk("unmapped data", rd, '0);
    xfer(1'h1, 12'h008, '0);
    chk("unmapped write err", er, 1'h1);
    xfer(1'h1, fdmd_off_status, 32'hffff_ffff);
    chk("ro write", er, '0);
    pstrb <= 4'he;
    xfer(1'h1, fdmd_off_ctrl, 32'h0000_0001);
    pstrb <= 4'hf;
    xfer(1'h0, fdmd_off_ctrl, '0);
    chk("lane gated write", rd, 32'h0000_0006);
    xfer(1'h0, fdmd_off_status, '0);
    chk("ro write kept", {rd[10:8], rd[5:4], rd[1:0]}, exp_st(5'h1e));
    $display("bus test done");
    wrap_up();
  end
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule : fdmd_test
